// >>> rtl/gpio_pkg.sv
// Shared constants of the port B, C and D general-purpose I/O block
package gpio_pkg;

	// ------------------------------------------------------------------
	// Port widths
	// ------------------------------------------------------------------
	localparam int PORT_B_W = 8;
	localparam int PORT_C_W = 7;
	localparam int PORT_D_W = 8;

	// ------------------------------------------------------------------
	// Register offsets on the plain register port
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_B_DATA = 8'h01;
	localparam logic [7:0] ADDR_C_DATA = 8'h02;
	localparam logic [7:0] ADDR_D_DATA = 8'h03;
	localparam logic [7:0] ADDR_B_DIR = 8'h05;
	localparam logic [7:0] ADDR_C_DIR = 8'h06;
	localparam logic [7:0] ADDR_D_DIR = 8'h07;
	localparam logic [7:0] ADDR_C_PUE = 8'h0C;
	localparam logic [7:0] ADDR_D_PUE = 8'h0D;
	localparam logic [7:0] ADDR_PERIPH_CTL = 8'h10;
	localparam logic [7:0] ADDR_TIMER_ELS = 8'h11;

	// ------------------------------------------------------------------
	// Field positions of the peripheral control register
	// ------------------------------------------------------------------
	localparam int CTL_CAN_EN = 0;
	localparam int CTL_SPI_EN = 1;
	localparam int CTL_SPI_MSTR = 2;
	localparam int CTL_MCLK_EN = 3;
	localparam int CTL_W = 4;

	// Pin positions of the shared port C pins
	localparam int CAN_TX_PIN = 0;
	localparam int CAN_RX_PIN = 1;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] PUE_RESET = 8'h00;
	localparam logic [3:0] CTL_RESET = 4'h0;
	localparam logic [7:0] ELS_RESET = 8'h00;
	localparam logic [7:0] OE_N_RESET = 8'hFF;
	localparam logic [7:0] ZERO_RESET = 8'h00;

endpackage : gpio_pkg

// >>> rtl/level_sync.sv
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
module level_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;	// First stage, read only by second
		logic [W-1:0] stable;	// Second stage, safe to use
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;

	// Shift the pin levels through both stages
	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.meta = async_in;
			st_nxt.stable = st_r.meta;
		end
	end

	// Register the stages
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;

endmodule : level_sync

// >>> rtl/pin_drive.sv
// Per-port pin drive selection and readback choice
`timescale 1ns/1ps
module pin_drive #(
	parameter int W = 8
) (
	input wire logic [W-1:0] latch,
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] own,
	input wire logic [W-1:0] per_out,
	input wire logic [W-1:0] per_oe,
	input wire logic [W-1:0] level,
	output logic [W-1:0] drv_out,
	output logic [W-1:0] drv_oe_n,
	output logic [W-1:0] rd_val
);

	// ------------------------------------------------------------------
	// Drive and readback
	// ------------------------------------------------------------------
	// A peripheral that owns a pin overrides latch and direction
	always_comb begin
		drv_out = (own & per_out) | (~own & latch);
		drv_oe_n = ~((own & per_oe) | (~own & dir));
		// Direction bit picks latch or pin even for owned pins
		rd_val = (dir & latch) | (~dir & level);
	end

endmodule : pin_drive

// >>> rtl/gpio_ports.sv
// Port B, C and D general-purpose I/O with peripheral pin sharing
`timescale 1ns/1ps

module gpio_ports (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Pins of port B
	input wire logic [7:0] port_b_pin_in,
	output logic [7:0] port_b_pin_out,
	output logic [7:0] port_b_pin_oe_n,
	// Pins of port C
	input wire logic [6:0] port_c_pin_in,
	output logic [6:0] port_c_pin_out,
	output logic [6:0] port_c_pin_oe_n,
	output logic [6:0] port_c_pullup_on,
	output logic [6:0] port_c_pin_level,
	// Pins of port D
	input wire logic [7:0] port_d_pin_in,
	output logic [7:0] port_d_pin_out,
	output logic [7:0] port_d_pin_oe_n,
	output logic [7:0] port_d_pullup_on,
	output logic [7:0] port_d_pin_level,
	// Peripheral side
	input wire logic can_tx_data,
	input wire logic [3:0] timer_out,
	input wire logic [3:0] timer_oe,
	input wire logic [3:0] spi_out,
	input wire logic [3:0] spi_oe,
	input wire logic mclk_in
);

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] dir_b;	// Port B direction
		logic [6:0] dir_c;	// Port C direction
		logic [7:0] dir_d;	// Port D direction
		logic [6:0] pue_c;	// Port C pullup enables
		logic [7:0] pue_d;	// Port D pullup enables
		logic [3:0] ctl;	// Peripheral pin enables
		logic [7:0] els;	// Timer edge/level select pairs
		logic [7:0] rd_data;	// Read answer
		logic [7:0] b_out;	// Registered pin drive, port B
		logic [7:0] b_oe_n;
		logic [6:0] c_out;	// Registered pin drive, port C
		logic [6:0] c_oe_n;
		logic [6:0] c_pu;
		logic [7:0] d_out;	// Registered pin drive, port D
		logic [7:0] d_oe_n;
		logic [7:0] d_pu;
	} state_t;

	// Data latches live apart: reset must not touch them
	typedef struct packed {
		logic [7:0] b;
		logic [6:0] c;
		logic [7:0] d;
	} latch_t;

	state_t st_r;
	state_t st_nxt;
	latch_t lat_r;
	latch_t lat_nxt;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [7:0] b_lvl;	// Synchronised port B levels
	logic [6:0] c_lvl;	// Synchronised port C levels
	logic [7:0] d_lvl;	// Synchronised port D levels

	level_sync #(
		.W(gpio_pkg::PORT_B_W + gpio_pkg::PORT_C_W + gpio_pkg::PORT_D_W)
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.async_in({port_b_pin_in, port_c_pin_in, port_d_pin_in}),
		.sync_out({b_lvl, c_lvl, d_lvl})
	);

	// ------------------------------------------------------------------
	// Pin ownership
	// ------------------------------------------------------------------
	logic can_en;	// CAN owns port C pins 1 and 0
	logic spi_en;	// SPI owns port D pins 3 to 1
	logic spi_slave;	// SPI also owns pin 0 as slave select
	logic mclk_en;	// Clock output on port D pin 0
	logic [6:0] own_c;
	logic [6:0] per_out_c;
	logic [6:0] per_oe_c;
	logic [7:0] own_d;
	logic [7:0] per_out_d;
	logic [7:0] per_oe_d;
	logic [3:0] tim_own;	// One per timer channel, pins 7 to 4

	assign can_en = st_r.ctl[gpio_pkg::CTL_CAN_EN];
	assign spi_en = st_r.ctl[gpio_pkg::CTL_SPI_EN];
	assign spi_slave = spi_en & ~st_r.ctl[gpio_pkg::CTL_SPI_MSTR];
	assign mclk_en = st_r.ctl[gpio_pkg::CTL_MCLK_EN];

	// A channel is live when its edge/level pair is non-zero
	generate
		for (genvar i = 0; i < 4; i++) begin : g_tim
			assign tim_own[i] = |st_r.els[2*i+1:2*i];
		end
	endgenerate

	// Port C: transmit drives pin 0, receive leaves pin 1 as input
	always_comb begin
		own_c = 7'h00;
		per_out_c = 7'h00;
		per_oe_c = 7'h00;
		own_c[gpio_pkg::CAN_TX_PIN] = can_en;
		own_c[gpio_pkg::CAN_RX_PIN] = can_en;
		per_out_c[gpio_pkg::CAN_TX_PIN] = can_tx_data;
		per_oe_c[gpio_pkg::CAN_TX_PIN] = 1'b1;
	end

	// Port D: timers on 7..4, SPI on 3..1, slave select or clock on 0
	always_comb begin
		own_d = {tim_own, {3{spi_en}}, spi_slave | mclk_en};
		per_out_d = {timer_out, spi_out[3:1], 1'b0};
		per_oe_d = {timer_oe, spi_oe[3:1], 1'b0};
		// Slave select wins over the clock output on pin 0
		if (spi_slave) begin
			per_out_d[0] = spi_out[0];
			per_oe_d[0] = spi_oe[0];
		end else if (mclk_en) begin
			per_out_d[0] = mclk_in;
			per_oe_d[0] = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Drive selection per port
	// ------------------------------------------------------------------
	logic [7:0] b_drv;
	logic [7:0] b_drv_oe_n;
	logic [7:0] b_rd;
	logic [6:0] c_drv;
	logic [6:0] c_drv_oe_n;
	logic [6:0] c_rd;
	logic [7:0] d_drv;
	logic [7:0] d_drv_oe_n;
	logic [7:0] d_rd;

	pin_drive #(.W(gpio_pkg::PORT_B_W)) u_drv_b (
		.latch(lat_r.b),
		.dir(st_r.dir_b),
		.own(8'h00),
		.per_out(8'h00),
		.per_oe(8'h00),
		.level(b_lvl),
		.drv_out(b_drv),
		.drv_oe_n(b_drv_oe_n),
		.rd_val(b_rd)
	);

	pin_drive #(.W(gpio_pkg::PORT_C_W)) u_drv_c (
		.latch(lat_r.c),
		.dir(st_r.dir_c),
		.own(own_c),
		.per_out(per_out_c),
		.per_oe(per_oe_c),
		.level(c_lvl),
		.drv_out(c_drv),
		.drv_oe_n(c_drv_oe_n),
		.rd_val(c_rd)
	);

	pin_drive #(.W(gpio_pkg::PORT_D_W)) u_drv_d (
		.latch(lat_r.d),
		.dir(st_r.dir_d),
		.own(own_d),
		.per_out(per_out_d),
		.per_oe(per_oe_d),
		.level(d_lvl),
		.drv_out(d_drv),
		.drv_oe_n(d_drv_oe_n),
		.rd_val(d_rd)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Register writes, read answer and pin drive
	always_comb begin
		st_nxt = st_r;
		lat_nxt = lat_r;
		if (ce) begin
			// Writes: latches always take the value
			if (wr_en) begin
				unique case (addr)
					gpio_pkg::ADDR_B_DATA: lat_nxt.b = wr_data;
					gpio_pkg::ADDR_C_DATA: lat_nxt.c = wr_data[6:0];
					gpio_pkg::ADDR_D_DATA: lat_nxt.d = wr_data;
					gpio_pkg::ADDR_B_DIR: st_nxt.dir_b = wr_data;
					gpio_pkg::ADDR_C_DIR: st_nxt.dir_c = wr_data[6:0];
					gpio_pkg::ADDR_D_DIR: st_nxt.dir_d = wr_data;
					gpio_pkg::ADDR_C_PUE: st_nxt.pue_c = wr_data[6:0];
					gpio_pkg::ADDR_D_PUE: st_nxt.pue_d = wr_data;
					gpio_pkg::ADDR_PERIPH_CTL: st_nxt.ctl = wr_data[3:0];
					gpio_pkg::ADDR_TIMER_ELS: st_nxt.els = wr_data;
					// Unmapped writes are dropped
					default: st_nxt.els = st_r.els;
				endcase
			end
			// Read answer stands only in the following cycle
			st_nxt.rd_data = gpio_pkg::ZERO_RESET;
			if (rd_en) begin
				unique case (addr)
					gpio_pkg::ADDR_B_DATA: st_nxt.rd_data = b_rd;
					gpio_pkg::ADDR_C_DATA: st_nxt.rd_data = {1'b0, c_rd};
					gpio_pkg::ADDR_D_DATA: st_nxt.rd_data = d_rd;
					gpio_pkg::ADDR_B_DIR: st_nxt.rd_data = st_r.dir_b;
					gpio_pkg::ADDR_C_DIR: st_nxt.rd_data = {1'b0, st_r.dir_c};
					gpio_pkg::ADDR_D_DIR: st_nxt.rd_data = st_r.dir_d;
					gpio_pkg::ADDR_C_PUE: st_nxt.rd_data = {1'b0, st_r.pue_c};
					gpio_pkg::ADDR_D_PUE: st_nxt.rd_data = st_r.pue_d;
					gpio_pkg::ADDR_PERIPH_CTL: st_nxt.rd_data = {4'h0, st_r.ctl};
					gpio_pkg::ADDR_TIMER_ELS: st_nxt.rd_data = st_r.els;
					// Unmapped reads answer zero
					default: st_nxt.rd_data = gpio_pkg::ZERO_RESET;
				endcase
			end
			// Pin drive registered so every output leaves a flop
			st_nxt.b_out = b_drv;
			st_nxt.b_oe_n = b_drv_oe_n;
			st_nxt.c_out = c_drv;
			st_nxt.c_oe_n = c_drv_oe_n;
			st_nxt.d_out = d_drv;
			st_nxt.d_oe_n = d_drv_oe_n;
			// Pullups only on input-configured pins
			st_nxt.c_pu = st_r.pue_c & ~st_r.dir_c;
			st_nxt.d_pu = st_r.pue_d & ~st_r.dir_d;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Control state with reset: directions cleared, pins released
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r.dir_b <= gpio_pkg::DIR_RESET;
			st_r.dir_c <= gpio_pkg::DIR_RESET[6:0];
			st_r.dir_d <= gpio_pkg::DIR_RESET;
			st_r.pue_c <= gpio_pkg::PUE_RESET[6:0];
			st_r.pue_d <= gpio_pkg::PUE_RESET;
			st_r.ctl <= gpio_pkg::CTL_RESET;
			st_r.els <= gpio_pkg::ELS_RESET;
			st_r.rd_data <= gpio_pkg::ZERO_RESET;
			st_r.b_out <= gpio_pkg::ZERO_RESET;
			st_r.b_oe_n <= gpio_pkg::OE_N_RESET;
			st_r.c_out <= gpio_pkg::ZERO_RESET[6:0];
			st_r.c_oe_n <= gpio_pkg::OE_N_RESET[6:0];
			st_r.c_pu <= gpio_pkg::ZERO_RESET[6:0];
			st_r.d_out <= gpio_pkg::ZERO_RESET;
			st_r.d_oe_n <= gpio_pkg::OE_N_RESET;
			st_r.d_pu <= gpio_pkg::ZERO_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Data latches keep their content through reset
	always_ff @(posedge clk) begin
		lat_r <= lat_nxt;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rd_data = st_r.rd_data;
	assign port_b_pin_out = st_r.b_out;
	assign port_b_pin_oe_n = st_r.b_oe_n;
	assign port_c_pin_out = st_r.c_out;
	assign port_c_pin_oe_n = st_r.c_oe_n;
	assign port_c_pullup_on = st_r.c_pu;
	assign port_c_pin_level = c_lvl;
	assign port_d_pin_out = st_r.d_out;
	assign port_d_pin_oe_n = st_r.d_oe_n;
	assign port_d_pullup_on = st_r.d_pu;
	assign port_d_pin_level = d_lvl;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence dir_b_write_s;
		ce && wr_en && addr == gpio_pkg::ADDR_B_DIR ##1 ce;
	endsequence
	dir_drives_pin_a: assert property (
		dir_b_write_s |=> port_b_pin_oe_n == ~$past(wr_data, 2))
		else $error("port B enable does not follow direction");
	reset_inputs_a: assert property (
		$rose(resetn) |-> port_b_pin_oe_n == 8'hFF
			&& port_c_pin_oe_n == 7'h7F && port_d_pin_oe_n == 8'hFF)
		else $error("pins driven right after reset");
	read_b_mix_a: assert property (
		ce && rd_en && addr == gpio_pkg::ADDR_B_DATA |=>
			rd_data == ($past(lat_r.b & st_r.dir_b)
				| $past(b_lvl & ~st_r.dir_b)))
		else $error("port B readback wrong");
	read_c_mix_a: assert property (
		ce && rd_en && addr == gpio_pkg::ADDR_C_DATA |=>
			rd_data == {1'b0, $past(lat_r.c & st_r.dir_c)
				| $past(c_lvl & ~st_r.dir_c)})
		else $error("port C readback wrong");
	read_d_mix_a: assert property (
		ce && rd_en && addr == gpio_pkg::ADDR_D_DATA |=>
			rd_data == ($past(lat_r.d & st_r.dir_d)
				| $past(d_lvl & ~st_r.dir_d)))
		else $error("port D readback wrong");
	latch_write_a: assert property (
		ce && wr_en && addr == gpio_pkg::ADDR_D_DATA |=>
			lat_r.d == $past(wr_data))
		else $error("port D latch not written");
	pullup_off_out_a: assert property (
		ce |=> (port_c_pullup_on & $past(st_r.dir_c)) == 7'h00)
		else $error("port C pullup on an output pin");
	pullup_input_a: assert property (
		ce && st_r.dir_d == 8'h00 |=> port_d_pullup_on == $past(st_r.pue_d))
		else $error("port D pullup does not follow enable");
	can_tx_pin_a: assert property (
		ce && can_en |=> !port_c_pin_oe_n[gpio_pkg::CAN_TX_PIN]
			&& port_c_pin_out[gpio_pkg::CAN_TX_PIN] == $past(can_tx_data))
		else $error("CAN transmit not on port C pin 0");
	timer_pin_a: assert property (
		ce && tim_own[3] |=> port_d_pin_out[7] == $past(timer_out[3])
			&& port_d_pin_oe_n[7] == !$past(timer_oe[3]))
		else $error("timer channel not on port D pin 7");
	spi_pins_a: assert property (
		ce && spi_en |=> port_d_pin_out[3:1] == $past(spi_out[3:1])
			&& port_d_pin_oe_n[3:1] == ~$past(spi_oe[3:1]))
		else $error("SPI pins not driven by SPI");
	slave_select_a: assert property (
		ce && spi_slave |=> port_d_pin_oe_n[0] == !$past(spi_oe[0]))
		else $error("direction bit leaks onto slave select");

endmodule : gpio_ports

// >>> tb/pin_board.sv
// Board-side model of one port: resolves each pin from all its drivers
`timescale 1ns/1ps
module pin_board #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic [W-1:0] drv_val,
	input wire logic [W-1:0] drv_oe_n,
	input wire logic [W-1:0] pull_on,
	input wire logic [W-1:0] ext_val,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] level
);
	// Pattern seen on a pin that nobody drives and nothing pulls
	logic [W-1:0] churn_r = {W{1'h0}};

	// ------------------------------------------------------------------
	// Floating pattern
	// ------------------------------------------------------------------
	// Changes every cycle so a stale value never passes for a real one
	always @(posedge clk) begin
		churn_r <= ~churn_r;
	end

	// ------------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------------
	// Device driver first, then board driver, then pullup, else floating
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (!drv_oe_n[i]) begin
				level[i] = drv_val[i];
			end else if (ext_en[i]) begin
				level[i] = ext_val[i];
			end else if (pull_on[i]) begin
				level[i] = 1'h1;
			end else begin
				level[i] = churn_r[i];
			end
		end
	end
endmodule : pin_board

// >>> tb/tb_gpio_ports.sv
// Self-checking bench for the port B, C and D I/O block
`timescale 1ns/1ps
module tb_gpio_ports;
	// Design side signals
	logic clk, resetn, ce, wr_en, rd_en, can_tx_data, mclk_in;
	logic [7:0] addr, wr_data, rd_data;
	logic [7:0] b_out, b_oe_n, b_lvl, d_out, d_oe_n, d_pu, d_lvl, d_sync;
	logic [6:0] c_out, c_oe_n, c_pu, c_lvl, c_sync;
	logic [3:0] timer_out, timer_oe, spi_out, spi_oe;
	// Board drivers
	logic [7:0] ext_b, ext_d, ext_en_b, ext_en_d;
	logic [6:0] ext_c, ext_en_c;
	int err_total, samples_checked;

	gpio_ports gpio_ports_inst (.clk(clk), .resetn(resetn), .ce(ce),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .port_b_pin_in(b_lvl), .port_b_pin_out(b_out),
		.port_b_pin_oe_n(b_oe_n), .port_c_pin_in(c_lvl),
		.port_c_pin_out(c_out), .port_c_pin_oe_n(c_oe_n),
		.port_c_pullup_on(c_pu), .port_c_pin_level(c_sync),
		.port_d_pin_in(d_lvl), .port_d_pin_out(d_out),
		.port_d_pin_oe_n(d_oe_n), .port_d_pullup_on(d_pu),
		.port_d_pin_level(d_sync), .can_tx_data(can_tx_data),
		.timer_out(timer_out), .timer_oe(timer_oe), .spi_out(spi_out),
		.spi_oe(spi_oe), .mclk_in(mclk_in));
	pin_board #(.W(8)) board_b (.clk(clk), .drv_val(b_out),
		.drv_oe_n(b_oe_n), .pull_on(8'h00), .ext_val(ext_b),
		.ext_en(ext_en_b), .level(b_lvl));
	pin_board #(.W(7)) board_c (.clk(clk), .drv_val(c_out),
		.drv_oe_n(c_oe_n), .pull_on(c_pu), .ext_val(ext_c),
		.ext_en(ext_en_c), .level(c_lvl));
	pin_board #(.W(8)) board_d (.clk(clk), .drv_val(d_out),
		.drv_oe_n(d_oe_n), .pull_on(d_pu), .ext_val(ext_d),
		.ext_en(ext_en_d), .level(d_lvl));

	// ------------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------------
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask : chk
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask : wr
	// One-cycle read strobe, data taken in the following cycle
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1 chk(rd_data, exp, what);
	endtask : rchk
	// Let pin outputs and synchronisers catch up
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// Tests take about 150 cycles; cut a hang at 10000
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		resetn = 1'h0;
		ce = 1'h1;
		{wr_en, rd_en, can_tx_data, mclk_in} = 4'h0;
		{addr, wr_data} = 16'h0000;
		{timer_out, timer_oe, spi_out, spi_oe} = 16'h0000;
		{ext_b, ext_en_b, ext_d, ext_en_d} = 32'h3CFF96FF;
		ext_c = 7'h02;
		ext_en_c = 7'h02;
		err_total = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'h1;
		settle();
		// Everything comes up as input
		chk(b_oe_n, 8'hFF, "b oe");
		chk({1'h0, c_oe_n}, 8'h7F, "c oe");
		chk(d_oe_n, 8'hFF, "d oe");
		rchk(gpio_pkg::ADDR_D_DIR, 8'h00, "d dir");
		rchk(gpio_pkg::ADDR_B_DATA, 8'h3C, "b pins");
		$display("test reset done");
		// Latch written first survives a reset in mid-run
		wr(gpio_pkg::ADDR_B_DATA, 8'hA5);
		@(posedge clk);
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		rchk(gpio_pkg::ADDR_B_DIR, 8'h00, "b dir");
		wr(gpio_pkg::ADDR_B_DIR, 8'hFF);
		settle();
		chk(b_oe_n, 8'h00, "b oe");
		chk(b_out, 8'hA5, "b out");
		rchk(gpio_pkg::ADDR_B_DATA, 8'hA5, "b latch");
		// Mixed directions: inputs read pins, writes reach only the latch
		wr(gpio_pkg::ADDR_B_DIR, 8'h0F);
		wr(gpio_pkg::ADDR_B_DATA, 8'hC3);
		settle();
		chk(b_oe_n, 8'hF0, "b oe");
		chk(b_out & 8'h0F, 8'h03, "b out");
		rchk(gpio_pkg::ADDR_B_DATA, 8'h33, "b mix");
		wr(gpio_pkg::ADDR_B_DIR, 8'hFF);
		rchk(gpio_pkg::ADDR_B_DATA, 8'hC3, "b latch");
		$display("test port b done");
		// Port C pullups only on inputs, seven bits wide
		wr(gpio_pkg::ADDR_C_PUE, 8'hFF);
		wr(gpio_pkg::ADDR_C_DATA, 8'h85);
		wr(gpio_pkg::ADDR_C_DIR, 8'h0F);
		settle();
		chk({1'h0, c_pu}, 8'h70, "c pullup");
		chk({1'h0, c_oe_n}, 8'h70, "c oe");
		rchk(gpio_pkg::ADDR_C_PUE, 8'h7F, "c pue");
		rchk(gpio_pkg::ADDR_C_DATA, 8'h75, "c read");
		// CAN takes C0 as transmit and releases C1 as receive
		@(posedge clk);
		can_tx_data <= 1'h1;
		wr(gpio_pkg::ADDR_PERIPH_CTL, 8'h01);
		settle();
		chk({1'h0, c_oe_n & 7'h03}, 8'h02, "can oe");
		chk({1'h0, c_out & 7'h01}, 8'h01, "can tx");
		chk({1'h0, c_sync & 7'h02}, 8'h02, "can rx");
		wr(gpio_pkg::ADDR_PERIPH_CTL, 8'h00);
		settle();
		chk({1'h0, c_oe_n & 7'h03}, 8'h00, "c gpio");
		$display("test port c done");
		// Each timer pin taken over by its own select pair
		wr(gpio_pkg::ADDR_D_DIR, 8'h00);
		@(posedge clk);
		timer_out <= 4'hA;
		timer_oe <= 4'hF;
		for (int k = 0; k < 4; k++) begin
			wr(gpio_pkg::ADDR_TIMER_ELS, 8'h01 << (2 * k));
			settle();
			chk(d_oe_n, ~(8'h10 << k), "tim oe");
			chk(d_out & (8'h10 << k), 8'hA0 & (8'h10 << k), "tim");
		end
		$display("test timers done");
		// SPI slave owns D3..D0; direction only picks readback
		wr(gpio_pkg::ADDR_TIMER_ELS, 8'h00);
		wr(gpio_pkg::ADDR_D_DATA, 8'h00);
		wr(gpio_pkg::ADDR_D_DIR, 8'hFF);
		@(posedge clk);
		spi_out <= 4'hF;
		spi_oe <= 4'h5;
		wr(gpio_pkg::ADDR_PERIPH_CTL, 8'h02);
		settle();
		chk(d_oe_n, 8'h0A, "spi oe");
		chk(d_out & 8'h05, 8'h05, "spi out");
		rchk(gpio_pkg::ADDR_D_DATA, 8'h00, "d latch");
		wr(gpio_pkg::ADDR_D_DIR, 8'h00);
		settle();
		chk(d_oe_n, 8'hFA, "spi dir");
		rchk(gpio_pkg::ADDR_D_DATA, 8'h97, "d pins");
		chk(d_sync, 8'h97, "d level");
		// Master mode frees D0; clock output then takes it
		wr(gpio_pkg::ADDR_D_DIR, 8'hFF);
		wr(gpio_pkg::ADDR_PERIPH_CTL, 8'h06);
		settle();
		chk({d_oe_n[0], d_out[0]}, 8'h00, "d0 gpio");
		@(posedge clk);
		mclk_in <= 1'h1;
		wr(gpio_pkg::ADDR_PERIPH_CTL, 8'h0E);
		settle();
		chk({d_oe_n[0], d_out[0]}, 8'h01, "d0 clock");
		// Port D pullups only on inputs
		wr(gpio_pkg::ADDR_D_DIR, 8'h0F);
		wr(gpio_pkg::ADDR_D_PUE, 8'hFF);
		settle();
		chk(d_pu, 8'hF0, "d pullup");
		// Clock enable low drops the strobe and holds the latch
		@(posedge clk);
		ce <= 1'h0;
		wr(gpio_pkg::ADDR_D_DATA, 8'h5A);
		ce <= 1'h1;
		rchk(gpio_pkg::ADDR_D_DATA, 8'h90, "ce hold");
		rchk(8'h20, 8'h00, "unmapped");
		$display("test port d done");
		wrap_up();
	end
endmodule : tb_gpio_ports
